// ==== sfcfe_top.sv ====
// Serial flash command front end: link framing and command checking
// Operation
// - Ignore program or erase touching protected range
// - Complement zero maps: none or whole array
// - Complement one, granule select zero: inverted whole-array choices
// - Level 001 bottom protects 000000h to 00EFFFh
// - Level 10X/110 bottom protects lower half
// - Level 010 top protects 002000h upward
// - Level 011 top protects 004000h upward
// - Level 10X/110 top protects upper half
// - Most significant bit first, from first edge
// - Opcode bits sampled on rising link clock
// - One opcode byte, then address/data/nothing
// - Reads return data until host deselects
// - Off-boundary write commands rejected entirely
// - Partial program byte keeps write latch set
// - Dual IO read: two-line address, mode, data
// - Quad IO read: mode, two dummies, quad data
// - Quad program: single address, quad data
// - Write latch required before program or erase
`timescale 1ns/1ps
`default_nettype none
module sfcfe_top
  import sfcfe_pkg::*;
#(
  parameter int DCNT_W = 9
) (
  // System clock domain
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_n,
  // Protection configuration
  input wire logic protect_complement,
  input wire logic small_granule_select,
  input wire logic top_bottom_select,
  input wire logic protect_level_hi,
  input wire logic protect_level_mid,
  input wire logic protect_level_lo,
  // Array read data returned on reads
  input wire logic [7:0] read_byte,
  // Command results
  output logic write_latch_flag,
  output logic cmd_exec,
  output logic cmd_reject,
  output logic cmd_blocked,
  output logic [7:0] cmd_opcode,
  output logic [23:0] cmd_addr,
  output logic [DCNT_W-1:0] cmd_count,
  output logic [7:0] cmd_data
);
  if (DCNT_W < DCNT_W_MIN) begin : g_chk
    $error("sfcfe_top data counter too narrow for a page");
  end

  // Bits per clock for an opcode in a phase
  function automatic logic [2:0] lane_step(input logic [7:0] op, input sfcfe_phase_t ph);
    logic [2:0] s;
    s = STEP1;
    case (ph)
      PH_ADDR, PH_MODE: begin
        if (op == OP_DIO2) s = STEP2;
        else if (op == OP_QIO4) s = STEP4;
      end
      PH_DUMMY: if (op == OP_QIO4) s = STEP4;
      PH_DIN: if (op == OP_QPP) s = STEP4;
      PH_DOUT: begin
        if (op == OP_DIO2 || op == OP_DOUT2) s = STEP2;
        else if (op == OP_QIO4 || op == OP_DOUT4) s = STEP4;
      end
      default: s = STEP1;
    endcase
    return s;
  endfunction

  // ---------------- Link domain ----------------
  logic frame_clr;
  logic first_ff;
  logic ftog_ff;
  logic nxt_ftog;
  sfcfe_phase_t phase_ff, nxt_phase, cur_ph;
  logic [2:0] bcnt_ff, nxt_bcnt, step;
  logic [1:0] byte_ff, nxt_byte;
  logic [7:0] sh_ff, nxt_sh, sh_in, op_now;
  logic [7:0] op_ff, nxt_op, obyte_ff, nxt_obyte;
  logic [23:0] addr_ff, nxt_addr;
  logic opdone_ff, nxt_opdone;
  logic [DCNT_W-1:0] dcnt_ff, nxt_dcnt;
  logic [7:0] dfirst_ff, nxt_dfirst;
  logic [3:0] sum;
  logic [7:0] stat_byte;
  logic [7:0] stat_s, rd_s;
  logic [3:0] nxt_io_out, nxt_io_oe_n;
  logic [3:0] io_out_ff, io_oe_n_ff;
  logic [2:0] pos, ostep;
  logic wel_ff;

  assign frame_clr = rst | cs_n;

  // Status and read data into the link domain
  sfcfe_sync #(.W(16)) u_lsync (
    .clk(link_clk),
    .rst(rst),
    .en(1'b1),
    .d({stat_byte, read_byte}),
    .q({stat_s, rd_s})
  );

  // Frame start flag, raised while deselected
  always_ff @(posedge link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  // Bit framing and phase sequencing
  always_comb begin
    cur_ph = first_ff ? PH_OP : phase_ff;
    step = lane_step(op_ff, cur_ph);
    case (step)
      STEP1: sh_in = {sh_ff[6:0], io_in[0]};
      STEP2: sh_in = {sh_ff[5:0], io_in[1], io_in[0]};
      default: sh_in = {sh_ff[3:0], io_in[3:0]};
    endcase
    sum = {1'b0, (first_ff ? 3'h0 : bcnt_ff)} + {1'b0, step};
    op_now = (cur_ph == PH_OP) ? sh_in : op_ff;
    nxt_ftog = first_ff ? !ftog_ff : ftog_ff;
    nxt_phase = cur_ph;
    nxt_bcnt = sum[2:0];
    nxt_sh = sh_in;
    nxt_byte = first_ff ? 2'h0 : byte_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_opdone = first_ff ? 1'b0 : opdone_ff;
    nxt_dcnt = first_ff ? '0 : dcnt_ff;
    nxt_dfirst = dfirst_ff;
    nxt_obyte = obyte_ff;
    if (sum[3]) begin
      case (cur_ph)
        PH_OP: begin
          nxt_op = sh_in;
          nxt_opdone = 1'b1;
          nxt_byte = 2'h0;
          case (sh_in)
            OP_READ, OP_FAST, OP_DOUT2, OP_DIO2, OP_DOUT4, OP_QIO4,
            OP_PP, OP_QPP, OP_SE4, OP_BE32, OP_BE64: nxt_phase = PH_ADDR;
            OP_RDSR: nxt_phase = PH_DOUT;
            default: nxt_phase = PH_DIN;
          endcase
        end
        PH_ADDR: begin
          nxt_addr = {addr_ff[15:0], sh_in};
          nxt_byte = byte_ff + 2'h1;
          if (byte_ff == ADDR_LAST) begin
            nxt_byte = 2'h0;
            case (op_ff)
              OP_DIO2, OP_QIO4: nxt_phase = PH_MODE;
              OP_FAST, OP_DOUT2, OP_DOUT4: nxt_phase = PH_DUMMY;
              OP_READ: nxt_phase = PH_DOUT;
              default: nxt_phase = PH_DIN;
            endcase
          end
        end
        PH_MODE: nxt_phase = (op_ff == OP_QIO4) ? PH_DUMMY : PH_DOUT;
        PH_DUMMY: begin
          nxt_byte = byte_ff + 2'h1;
          if (byte_ff == ((op_ff == OP_QIO4) ? DUMMY_LAST_QUAD : DUMMY_LAST_STD)) begin
            nxt_byte = 2'h0;
            nxt_phase = PH_DOUT;
          end
        end
        PH_DIN: begin
          if (dcnt_ff == '0) nxt_dfirst = sh_in;
          if (dcnt_ff != '1) nxt_dcnt = dcnt_ff + 1'b1;
        end
        default: nxt_phase = PH_DOUT;
      endcase
      // Reload the outgoing byte at each byte boundary of the data-out phase
      if (nxt_phase == PH_DOUT) nxt_obyte = (op_now == OP_RDSR) ? stat_s : rd_s;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      ftog_ff <= 1'b0;
      phase_ff <= PH_OP;
      bcnt_ff <= 3'h0;
      byte_ff <= 2'h0;
      sh_ff <= 8'h00;
      op_ff <= 8'h00;
      addr_ff <= 24'h000000;
      opdone_ff <= 1'b0;
      dcnt_ff <= '0;
      dfirst_ff <= 8'h00;
      obyte_ff <= 8'h00;
    end else begin
      ftog_ff <= nxt_ftog;
      phase_ff <= nxt_phase;
      bcnt_ff <= nxt_bcnt;
      byte_ff <= nxt_byte;
      sh_ff <= nxt_sh;
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      opdone_ff <= nxt_opdone;
      dcnt_ff <= nxt_dcnt;
      dfirst_ff <= nxt_dfirst;
      obyte_ff <= nxt_obyte;
    end
  end

  // Data-out lanes, changed on the falling edge, MSB first
  always_comb begin
    nxt_io_out = 4'h0;
    nxt_io_oe_n = RST_OE_N;
    ostep = lane_step(op_ff, PH_DOUT);
    pos = 3'h7 - bcnt_ff;
    if (!first_ff && phase_ff == PH_DOUT) begin
      case (ostep)
        STEP1: begin
          nxt_io_out[1] = obyte_ff[pos];
          nxt_io_oe_n = 4'hD;
        end
        STEP2: begin
          nxt_io_out[1] = obyte_ff[pos];
          nxt_io_out[0] = obyte_ff[pos - 3'h1];
          nxt_io_oe_n = 4'hC;
        end
        default: begin
          nxt_io_out = obyte_ff[pos -: 4];
          nxt_io_oe_n = 4'h0;
        end
      endcase
    end
  end

  // Drivers released at once on deselect
  always_ff @(negedge link_clk or posedge frame_clr) begin
    if (frame_clr) begin
      io_out_ff <= 4'h0;
      io_oe_n_ff <= RST_OE_N;
    end else begin
      io_out_ff <= nxt_io_out;
      io_oe_n_ff <= nxt_io_oe_n;
    end
  end

  assign io_out = io_out_ff;
  assign io_oe_n = io_oe_n_ff;

  // ---------------- System domain ----------------
  logic sel_s, cs_d_ff, seen_ff, rise, valid, on_bnd, is_bnd, is_prog, is_erase, hit;
  logic nxt_cs_d, nxt_seen, nxt_wel, nxt_exec, nxt_reject, nxt_blocked;
  logic exec_ff, reject_ff, blocked_ff;
  logic [7:0] op_o_ff, nxt_op_o, data_o_ff, nxt_data_o;
  logic [23:0] addr_o_ff, nxt_addr_o;
  logic [DCNT_W-1:0] cnt_o_ff, nxt_cnt_o;
  logic p_en;
  logic [15:0] p_lo, p_hi, rmask, rlo, rhi;

  // Select synchronised active high, so its reset value matches idle
  sfcfe_sync #(.W(1)) u_cs_sync (
    .clk(clock),
    .rst(rst),
    .en(ce),
    .d(!cs_n),
    .q(sel_s)
  );

  sfcfe_prot u_prot (
    .protect_complement(protect_complement),
    .small_granule_select(small_granule_select),
    .top_bottom_select(top_bottom_select),
    .level({protect_level_hi, protect_level_mid, protect_level_lo}),
    .prot_en(p_en),
    .prot_lo(p_lo),
    .prot_hi(p_hi)
  );

  // Status byte presented to status reads
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[ST_WEL] = wel_ff;
    stat_byte[ST_BP_LO] = protect_level_lo;
    stat_byte[ST_BP_MID] = protect_level_mid;
    stat_byte[ST_BP_HI] = protect_level_hi;
    stat_byte[ST_TB] = top_bottom_select;
    stat_byte[ST_SEC] = small_granule_select;
    stat_byte[ST_CMP] = protect_complement;
  end

  // Frame evaluation once deselect is seen; link fields are static then
  always_comb begin
    rise = !sel_s && cs_d_ff; // Select just released
    valid = rise && (ftog_ff != seen_ff) && opdone_ff;
    on_bnd = (bcnt_ff == 3'h0);
    is_prog = (op_ff == OP_PP) || (op_ff == OP_QPP);
    is_erase = (op_ff == OP_SE4) || (op_ff == OP_BE32) || (op_ff == OP_BE64) ||
               (op_ff == OP_CE1) || (op_ff == OP_CE2);
    is_bnd = is_prog || is_erase || (op_ff == OP_WRSR) || (op_ff == OP_WREN) ||
             (op_ff == OP_WRDI) || (op_ff == OP_DPD);
    case (op_ff)
      OP_SE4: rmask = MASK_SEC4;
      OP_BE32: rmask = MASK_BLK32;
      OP_BE64, OP_CE1, OP_CE2: rmask = MASK_BLK64;
      default: rmask = MASK_PAGE;
    endcase
    rlo = addr_ff[15:0] & ~rmask;
    rhi = addr_ff[15:0] | rmask;
    hit = p_en && (rlo <= p_hi) && (rhi >= p_lo);
    nxt_cs_d = sel_s;
    nxt_seen = rise ? ftog_ff : seen_ff;
    nxt_wel = wel_ff;
    nxt_exec = 1'b0;
    nxt_reject = 1'b0;
    nxt_blocked = 1'b0;
    nxt_op_o = op_o_ff;
    nxt_addr_o = addr_o_ff;
    nxt_cnt_o = cnt_o_ff;
    nxt_data_o = data_o_ff;
    if (valid) begin
      nxt_op_o = op_ff;
      nxt_addr_o = addr_ff;
      nxt_cnt_o = dcnt_ff;
      nxt_data_o = dfirst_ff;
      if (is_bnd && !on_bnd) begin
        nxt_reject = 1'b1;
      end else if (op_ff == OP_WREN) begin
        nxt_wel = 1'b1;
      end else if (op_ff == OP_WRDI) begin
        nxt_wel = 1'b0;
      end else if (op_ff == OP_DPD) begin
        nxt_exec = 1'b1;
      end else if (wel_ff && (op_ff == OP_WRSR) && dcnt_ff != '0) begin
        nxt_exec = 1'b1;
        nxt_wel = 1'b0;
      end else if (wel_ff && (is_prog || is_erase) && (phase_ff == PH_DIN) &&
                   (!is_prog || dcnt_ff != '0)) begin
        nxt_blocked = hit;
        nxt_exec = !hit;
        nxt_wel = hit;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_d_ff <= 1'b0;
      seen_ff <= 1'b0;
      wel_ff <= RST_WEL;
      exec_ff <= 1'b0;
      reject_ff <= 1'b0;
      blocked_ff <= 1'b0;
      op_o_ff <= 8'h00;
      addr_o_ff <= 24'h000000;
      cnt_o_ff <= '0;
      data_o_ff <= 8'h00;
    end else if (ce) begin
      cs_d_ff <= nxt_cs_d;
      seen_ff <= nxt_seen;
      wel_ff <= nxt_wel;
      exec_ff <= nxt_exec;
      reject_ff <= nxt_reject;
      blocked_ff <= nxt_blocked;
      op_o_ff <= nxt_op_o;
      addr_o_ff <= nxt_addr_o;
      cnt_o_ff <= nxt_cnt_o;
      data_o_ff <= nxt_data_o;
    end
  end

  assign write_latch_flag = wel_ff;
  assign cmd_exec = exec_ff;
  assign cmd_reject = reject_ff;
  assign cmd_blocked = blocked_ff;
  assign cmd_opcode = op_o_ff;
  assign cmd_addr = addr_o_ff;
  assign cmd_count = cnt_o_ff;
  assign cmd_data = data_o_ff;

  // Checks on command outcome and range decode
  reject_bnd_a: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && is_bnd && !on_bnd) |=> (reject_ff && !exec_ff && $stable(wel_ff)))
    else $error("off-boundary command not rejected");
  prot_block_a: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && hit && (is_prog || is_erase)) |=> !exec_ff)
    else $error("protected region was modified");
  wel_set_a: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && op_ff == OP_WREN && on_bnd) |=> wel_ff)
    else $error("write enable did not set latch");
  exec_needs_wel_a: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && (is_prog || is_erase) && !wel_ff) |=> !exec_ff)
    else $error("program or erase ran without latch");
  partial_keep_a: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && is_prog && !on_bnd && wel_ff) |=> (wel_ff && !exec_ff))
    else $error("partial program byte cleared latch");
  dec_low15_a: assert property (@(posedge clock) disable iff (rst)
    (protect_complement && small_granule_select && !top_bottom_select &&
     {protect_level_hi, protect_level_mid, protect_level_lo} == 3'h1)
    |-> (p_en && p_lo == ARRAY_FIRST && p_hi == LOW_15_16_END))
    else $error("lower fifteen sixteenths decode wrong");
  dec_up34_a: assert property (@(posedge clock) disable iff (rst)
    (protect_complement && small_granule_select && top_bottom_select &&
     {protect_level_hi, protect_level_mid, protect_level_lo} == 3'h3)
    |-> (p_en && p_lo == UP_3_4_START && p_hi == ARRAY_LAST))
    else $error("upper three quarters decode wrong");
  dec_whole_a: assert property (@(posedge clock) disable iff (rst)
    (!protect_complement && !small_granule_select && {protect_level_mid, protect_level_lo} != 2'h0)
    |-> (p_en && p_lo == ARRAY_FIRST && p_hi == ARRAY_LAST))
    else $error("whole array decode wrong");
  dec_unmapped_a: assert property (@(posedge clock) disable iff (rst)
    (!protect_complement && small_granule_select &&
     {protect_level_hi, protect_level_mid, protect_level_lo} != 3'h7) |-> !p_en)
    else $error("unmapped code protects memory");
endmodule
`default_nettype wire

// ==== sfcfe_pkg.sv ====
// Shared constants and types of the serial flash command front end
package sfcfe_pkg;
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DOUT2 = 8'h3B;
  localparam logic [7:0] OP_DIO2 = 8'hBB;
  localparam logic [7:0] OP_DOUT4 = 8'h6B;
  localparam logic [7:0] OP_QIO4 = 8'hEB;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE4 = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_DPD = 8'hB9;
  // Phase byte counts (last index)
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [1:0] DUMMY_LAST_QUAD = 2'h1;
  localparam logic [1:0] DUMMY_LAST_STD = 2'h0;
  // Bits moved per clock
  localparam logic [2:0] STEP1 = 3'h1;
  localparam logic [2:0] STEP2 = 3'h2;
  localparam logic [2:0] STEP4 = 3'h4;
  // Protected range bounds inside the 64KB array
  localparam logic [15:0] ARRAY_FIRST = 16'h0000;
  localparam logic [15:0] ARRAY_LAST = 16'hFFFF;
  localparam logic [15:0] LOW_15_16_END = 16'hEFFF;
  localparam logic [15:0] LOW_HALF_END = 16'h7FFF;
  localparam logic [15:0] UP_7_8_START = 16'h2000;
  localparam logic [15:0] UP_3_4_START = 16'h4000;
  localparam logic [15:0] UP_HALF_START = 16'h8000;
  // Target region masks
  localparam logic [15:0] MASK_PAGE = 16'h00FF;
  localparam logic [15:0] MASK_SEC4 = 16'h0FFF;
  localparam logic [15:0] MASK_BLK32 = 16'h7FFF;
  localparam logic [15:0] MASK_BLK64 = 16'hFFFF;
  // Status byte bit positions
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_MID = 3;
  localparam int ST_BP_HI = 4;
  localparam int ST_TB = 5;
  localparam int ST_SEC = 6;
  localparam int ST_CMP = 7;
  // Reset values and minimum data counter width
  localparam logic RST_WEL = 1'b0;
  localparam logic [3:0] RST_OE_N = 4'hF;
  localparam int DCNT_W_MIN = 9;

  typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DIN, PH_DOUT} sfcfe_phase_t;
endpackage

// ==== sfcfe_sync.sv ====
// Two flip-flop level synchroniser with clock enable
`timescale 1ns/1ps
`default_nettype none
module sfcfe_sync
  import sfcfe_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  if (W < 1) begin : g_chk
    $error("sfcfe_sync width must be at least one");
  end

  // First stage feeds only the second
  always_comb begin
    nxt_meta = en ? d : meta_ff;
    nxt_sync = en ? meta_ff : sync_ff;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// ==== sfcfe_prot.sv ====
// Protection bits to protected address range decoder
`timescale 1ns/1ps
`default_nettype none
module sfcfe_prot
  import sfcfe_pkg::*;
(
  // Protection bits
  input wire logic protect_complement,
  input wire logic small_granule_select,
  input wire logic top_bottom_select,
  input wire logic [2:0] level,
  // Decoded range
  output logic prot_en,
  output logic [15:0] prot_lo,
  output logic [15:0] prot_hi
);
  // Range decode per complement and granule select
  always_comb begin
    prot_en = 1'b0;
    prot_lo = ARRAY_FIRST;
    prot_hi = ARRAY_LAST;
    if (!small_granule_select) begin
      prot_en = (level[1:0] == 2'h0) ? protect_complement : !protect_complement;
    end else if (!protect_complement) begin
      prot_en = (level == 3'h7);
    end else begin
      case (level)
        3'h0: prot_en = 1'b1;
        3'h1: begin
          prot_en = !top_bottom_select;
          prot_hi = LOW_15_16_END;
        end
        3'h2: begin
          prot_en = top_bottom_select;
          prot_lo = UP_7_8_START;
        end
        3'h3: begin
          prot_en = top_bottom_select;
          prot_lo = UP_3_4_START;
        end
        3'h4, 3'h5, 3'h6: begin
          prot_en = 1'b1;
          prot_lo = top_bottom_select ? UP_HALF_START : ARRAY_FIRST;
          prot_hi = top_bottom_select ? ARRAY_LAST : LOW_HALF_END;
        end
        default: prot_en = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== sfcfe_host.sv ====
// Host controller model driving the serial link of the front end
`timescale 1ns/1ps
`default_nettype none
module sfcfe_host (
  // Serial link
  output logic link_clk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out
);
  // Idle link: clock parked low, device deselected
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // One link clock: set lanes while low, sample on the rise
  task automatic clk1(input int w, input logic [3:0] d, output logic [3:0] q);
    io_in = d;
    #20 link_clk = 1'b1;
    q = (w == 1) ? {3'h0, io_out[1]} : io_out;
    #40 link_clk = 1'b0;
    #20;
  endtask
  // Send n bits of v over w lanes, top bit first
  task automatic shift(input int w, input logic [31:0] v, input int n);
    logic [3:0] q;
    for (int k = n - w; k >= 0; k -= w) begin
      clk1(w, 4'((v >> k) & ((1 << w) - 1)), q);
    end
  endtask
  // Collect n bits from w lanes; own lanes wiggle meanwhile
  task automatic fetch(input int w, input int n, output logic [31:0] r);
    logic [3:0] q;
    r = 32'h0;
    for (int k = 0; k < n; k += w) begin
      clk1(w, ~io_in, q);
      r = (r << w) | 32'(q & 4'((1 << w) - 1));
    end
  endtask
  // Select the device ahead of the first edge
  task automatic open_frame();
    cs_n = 1'b0;
    #40;
  endtask
  // Deselect only after the last bit; released lanes invert
  task automatic close_frame();
    #20 cs_n = 1'b1;
    io_in = ~io_in;
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfcfe_pkg::*;
  logic clock, rst, ce, link_clk, cs_n, latch, ex, rj, bl, ex_s, rj_s, bl_s;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [5:0] prot;
  logic [7:0] read_byte, op, dat;
  logic [23:0] addr;
  logic [8:0] cnt;
  int n_errors, comparisons;

  sfcfe_host host (.link_clk(link_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));
  sfcfe_top #(.DCNT_W(9)) dut (.clock(clock), .rst(rst), .ce(ce), .link_clk(link_clk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .protect_complement(prot[5]), .small_granule_select(prot[4]),
    .top_bottom_select(prot[3]), .protect_level_hi(prot[2]),
    .protect_level_mid(prot[1]), .protect_level_lo(prot[0]), .read_byte(read_byte),
    .write_latch_flag(latch), .cmd_exec(ex), .cmd_reject(rj), .cmd_blocked(bl),
    .cmd_opcode(op), .cmd_addr(addr), .cmd_count(cnt), .cmd_data(dat));

  // System clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Close a frame and gather result pulses over 8 clocks
  task automatic end_frame();
    host.close_frame();
    {ex_s, rj_s, bl_s} = 3'h0;
    repeat (8) begin
      @(posedge clock);
      #1;
      {ex_s, rj_s, bl_s} = {ex_s | ex, rj_s | rj, bl_s | bl};
    end
  endtask
  // Whole single-line command frame
  task automatic cmd(input logic [7:0] o, input logic [31:0] v, input int n);
    host.open_frame();
    host.shift(1, o, 8);
    host.shift(1, v, n);
    end_frame();
  endtask
  // Program with and without the write latch
  task automatic t_prog();
    check(latch, 0, "latch after reset");
    check(io_oe_n, 4'hF, "oe after reset");
    cmd(OP_WREN, 0, 0);
    check(latch, 1, "wren");
    cmd(OP_PP, 32'h001234A5, 32);
    check(ex_s, 1, "pp exec");
    check({op, addr}, 32'h02001234, "pp op addr");
    check({cnt, dat}, {9'h1, 8'hA5}, "pp data");
    check(latch, 0, "latch cleared");
    cmd(OP_PP, 32'h001234A5, 32);
    check(ex_s, 0, "pp without latch");
  endtask
  // Frames ending off a byte boundary
  task automatic t_bound();
    cmd(OP_WREN, 0, 1);
    check({rj_s, latch}, 2'b10, "wren 9 bits");
    cmd(OP_WREN, 0, 0);
    cmd(OP_PP, 32'h00012345, 28);
    check({rj_s, ex_s, latch}, 3'b101, "pp half byte");
    cmd(OP_WRDI, 0, 0);
    check(latch, 0, "wrdi");
  endtask
  // Sector erase under one protection setting
  task automatic erase(input logic [5:0] p, input logic [15:0] a, input logic b);
    @(posedge clock);
    prot <= p;
    cmd(OP_WREN, 0, 0);
    cmd(OP_SE4, {8'h0, a}, 24);
    check({bl_s, ex_s, latch}, {b, !b, b}, "erase");
  endtask
  // Protection map walk
  task automatic t_prot();
    erase(6'b000000, 16'h0000, 0);
    erase(6'b000001, 16'hF000, 1);
    erase(6'b000110, 16'h0000, 1);
    erase(6'b010000, 16'h0000, 0);
    erase(6'b010111, 16'h8000, 1);
    erase(6'b100000, 16'h5000, 1);
    erase(6'b100001, 16'h0000, 0);
    erase(6'b110000, 16'hF000, 1);
    erase(6'b110111, 16'h0000, 0);
    erase(6'b110001, 16'hF000, 0);
    erase(6'b110001, 16'hE000, 1);
    erase(6'b110101, 16'h8000, 0);
    erase(6'b110110, 16'h7000, 1);
    erase(6'b111010, 16'h1000, 0);
    erase(6'b111010, 16'h2000, 1);
    erase(6'b111011, 16'h3000, 0);
    erase(6'b111011, 16'h4000, 1);
    erase(6'b111100, 16'h7000, 0);
    erase(6'b111110, 16'h8000, 1);
    erase(6'b010001, 16'h0000, 0);
    erase(6'b111001, 16'hF000, 0);
  endtask
  // Status stream, dual and quad reads, quad program
  task automatic t_xfer();
    logic [31:0] r;
    @(posedge clock);
    prot <= 6'b101101;
    read_byte <= 8'h5A;
    cmd(OP_WREN, 0, 0);
    host.open_frame();
    host.shift(1, OP_RDSR, 8);
    host.fetch(1, 16, r);
    check({r[15:0], io_oe_n}, {16'hB6B6, 4'hD}, "status");
    end_frame();
    check(io_oe_n, 4'hF, "oe released");
    host.open_frame();
    host.shift(1, OP_DIO2, 8);
    host.shift(2, 32'h00135700, 32);
    host.fetch(2, 16, r);
    check({r[15:0], io_oe_n}, {16'h5A5A, 4'hC}, "dual data");
    end_frame();
    check({op, addr}, 32'hBB001357, "dual addr");
    host.open_frame();
    host.shift(1, OP_QIO4, 8);
    host.shift(4, 32'h00ABCD00, 32);
    host.shift(4, 0, 16);
    host.fetch(4, 16, r);
    check({r[15:0], io_oe_n}, {16'h5A5A, 4'h0}, "quad data");
    end_frame();
    check({op, addr}, 32'hEB00ABCD, "quad addr");
    @(posedge clock);
    prot <= 6'b000000;
    cmd(OP_WREN, 0, 0);
    host.open_frame();
    host.shift(1, OP_QPP, 8);
    host.shift(1, 32'h000300, 24);
    host.shift(4, 32'hC396, 16);
    end_frame();
    check({ex_s, cnt, dat}, {1'b1, 9'h2, 8'hC3}, "quad program");
  endtask
  // One read of the fixed array byte over w lanes
  task automatic rd(input logic [7:0] o, input int w, input int dm, input logic [3:0] oe);
    logic [31:0] r;
    host.open_frame();
    host.shift(1, o, 8);
    host.shift(1, 32'h000100, 24);
    host.shift(1, 0, dm);
    host.fetch(w, 8, r);
    check({r[7:0], io_oe_n}, {8'h5A, oe}, "read data");
    end_frame();
    check({op, addr}, {o, 24'h000100}, "read op addr");
  endtask
  // Remaining opcodes, a second reset and the clock enable
  task automatic t_cmds();
    rd(OP_READ, 1, 0, 4'hD);
    rd(OP_FAST, 1, 8, 4'hD);
    rd(OP_DOUT2, 2, 8, 4'hC);
    rd(OP_DOUT4, 4, 8, 4'h0);
    cmd(OP_WRSR, 32'h3C, 8);
    check({ex_s, latch}, 2'b00, "wrsr no latch");
    cmd(OP_WREN, 0, 0);
    cmd(OP_WRSR, 32'h3C, 8);
    check({ex_s, latch, dat}, {2'b10, 8'h3C}, "wrsr");
    cmd(OP_DPD, 0, 3);
    check({rj_s, ex_s}, 2'b10, "dpd off byte");
    cmd(OP_DPD, 0, 0);
    check({rj_s, ex_s}, 2'b01, "dpd");
    @(posedge clock);
    prot <= 6'b110101;
    cmd(OP_WREN, 0, 0);
    cmd(OP_BE64, 32'h8000, 24);
    check({bl_s, latch}, 2'b11, "block 64 hit");
    cmd(OP_BE32, 32'h8000, 24);
    check({ex_s, latch}, 2'b10, "block 32 free");
    cmd(OP_WREN, 0, 0);
    cmd(OP_CE1, 0, 0);
    check({bl_s, latch}, 2'b11, "chip erase hit");
    @(posedge clock);
    prot <= 6'b000000;
    cmd(OP_CE2, 0, 0);
    check({ex_s, latch}, 2'b10, "chip erase");
    cmd(OP_WREN, 0, 0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    check({latch, io_oe_n}, 5'h0F, "second reset");
    host.open_frame();
    host.shift(1, OP_WREN, 8);
    @(posedge clock);
    ce <= 1'b0;
    end_frame();
    check(latch, 0, "frozen");
    @(posedge clock);
    ce <= 1'b1;
    repeat (5) @(posedge clock);
    check(latch, 1, "thawed");
  endtask
  // Main sequence
  initial begin
    {rst, ce, prot, read_byte} = {1'b1, 1'b1, 6'h00, 8'h00};
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_prog();
    t_bound();
    t_prot();
    t_xfer();
    t_cmds();
    finish_test();
  end
  // Watchdog
  initial begin
    #1000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
